/* File: core/pes_consts.vh */
/*
 * Constants for the physical layer event status and diagnostic block.
 * Assumes inclusion by bare name from design files under core/.
 */
`ifndef PES_CONSTS_VH
`define PES_CONSTS_VH

// ****************************************************************
// Register addresses on the management interface
// ****************************************************************
`define PES_ADDR_W 5
`define PES_ADDR_EVENT 5'h11
`define PES_ADDR_DIAG 5'h12

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define PES_DATA_W 16
`define PES_NUM_EVENTS 8
`define PES_FLAG_LSB 0
`define PES_ENABLE_LSB 8
`define PES_EVENT_RESET 16'h0000
`define PES_DIAG_RESET 16'h0000
`define PES_DIAG_RX_DETECT_BIT 12
`define PES_DIAG_RX_LOCK_BIT 11

// ****************************************************************
// Event bit positions within the flag byte
// ****************************************************************
`define PES_EV_NEG_DONE 0
`define PES_EV_REMOTE_FAULT 1
`define PES_EV_LINK_CHANGE 2
`define PES_EV_PARTNER_ACK 3
`define PES_EV_PARALLEL_FAULT 4
`define PES_EV_PAGE_RECEIVED 5
`define PES_EV_RX_ERROR 6
`define PES_EV_JABBER 7

`endif

/* File: core/pes_event_status.v */
/*
 * Physical layer event flags, their enables, the interrupt toward the MAC
 * raw interrupt status, and the read-only negotiation diagnostic register.
 * Assumes a management-interface register port on the system clock:
 * single-cycle read and write strobes with a 5-bit register address.
 * Event inputs arrive from analog/link logic in other domains and are
 * synchronised here; each detection is a rising edge of its input level,
 * except link change, which is a fall of the link-good level.
 */
`timescale 1ns/1ps
`include "pes_consts.vh"
module pes_event_status #(
   parameter NUM_EVENTS = `PES_NUM_EVENTS,
   parameter DATA_W = `PES_DATA_W,
   parameter ADDR_W = `PES_ADDR_W
) (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_ce,
   input wire i_reg_rd,
   input wire i_reg_wr,
   input wire [ADDR_W-1:0] i_reg_addr,
   input wire [DATA_W-1:0] i_reg_wdata,
   output reg [DATA_W-1:0] o_reg_rdata,
   output reg o_reg_rvalid,
   input wire i_jabber,
   input wire i_rx_error,
   input wire i_page_received,
   input wire i_parallel_fault,
   input wire i_partner_ack,
   input wire i_link_ok,
   input wire i_remote_fault,
   input wire i_negotiation_done,
   input wire i_receive_detect,
   input wire i_receive_lock,
   output reg o_mac_raw_interrupt_status
);
   localparam SYNC_W = NUM_EVENTS + 2;
   localparam [DATA_W-1:0] EVENT_RESET = `PES_EVENT_RESET;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function is_addr;
      input [ADDR_W-1:0] addr;
      input [ADDR_W-1:0] target;
      begin
         is_addr = (addr == target);
      end
   endfunction

   wire rd_event = i_reg_rd && is_addr(i_reg_addr, `PES_ADDR_EVENT);
   wire wr_event = i_reg_wr && is_addr(i_reg_addr, `PES_ADDR_EVENT);
   wire rd_diag = i_reg_rd && is_addr(i_reg_addr, `PES_ADDR_DIAG);

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   wire [SYNC_W-1:0] raw_in;
   wire [SYNC_W-1:0] sync_lvl;

   // Link status is synchronised as it stands; its reset level of 0 reads as failed.
   assign raw_in[`PES_EV_NEG_DONE] = i_negotiation_done;
   assign raw_in[`PES_EV_REMOTE_FAULT] = i_remote_fault;
   assign raw_in[`PES_EV_LINK_CHANGE] = i_link_ok;
   assign raw_in[`PES_EV_PARTNER_ACK] = i_partner_ack;
   assign raw_in[`PES_EV_PARALLEL_FAULT] = i_parallel_fault;
   assign raw_in[`PES_EV_PAGE_RECEIVED] = i_page_received;
   assign raw_in[`PES_EV_RX_ERROR] = i_rx_error;
   assign raw_in[`PES_EV_JABBER] = i_jabber;
   assign raw_in[NUM_EVENTS] = i_receive_detect;
   assign raw_in[NUM_EVENTS+1] = i_receive_lock;

   pes_sync3 #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_async(raw_in),
      .o_level(sync_lvl)
   );

   // ****************************************************************
   // Event detection
   // ****************************************************************
   // The link bit is inverted after the synchroniser, so an OK to FAIL change
   // is a rising edge; both its level and its history reset to failed, so a
   // link that is down at power-up raises no spurious change flag.
   localparam [NUM_EVENTS-1:0] PREV_RESET =
      {{(NUM_EVENTS-1){1'b0}}, 1'b1} << `PES_EV_LINK_CHANGE;

   reg [NUM_EVENTS-1:0] prev_q;
   wire [NUM_EVENTS-1:0] evt_lvl = sync_lvl[NUM_EVENTS-1:0] ^ PREV_RESET;
   wire [NUM_EVENTS-1:0] evt_pulse = evt_lvl & ~prev_q;
   // Pulses above cover jabber, rx error, page, parallel fault, and also
   // partner ack, link fail, remote fault and negotiation done.

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_q <= PREV_RESET;
      end else if (i_ce) begin
         prev_q <= evt_lvl;
      end
   end

   // ****************************************************************
   // Event register: enables in the upper byte, flags in the lower
   // ****************************************************************
   reg [NUM_EVENTS-1:0] flag_q;
   reg [NUM_EVENTS-1:0] flag_d;
   reg [NUM_EVENTS-1:0] enable_q;
   reg [NUM_EVENTS-1:0] enable_d;

   always @* begin
      flag_d = flag_q;
      if (rd_event) begin
         flag_d = {NUM_EVENTS{1'b0}};
      end
      // Setting after the clear means a coincident event survives the read.
      flag_d = flag_d | evt_pulse;
      enable_d = enable_q;
      if (wr_event) begin
         enable_d = i_reg_wdata[`PES_ENABLE_LSB +: NUM_EVENTS];
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flag_q <= EVENT_RESET[`PES_FLAG_LSB +: NUM_EVENTS];
         enable_q <= EVENT_RESET[`PES_ENABLE_LSB +: NUM_EVENTS];
      end else if (i_ce) begin
         flag_q <= flag_d;
         enable_q <= enable_d;
      end
   end

   // ****************************************************************
   // Interrupt toward the MAC raw interrupt status
   // ****************************************************************
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mac_raw_interrupt_status <= 1'b0;
      end else if (i_ce) begin
         o_mac_raw_interrupt_status <= |(flag_d & enable_d);
      end
   end

   // ****************************************************************
   // Diagnostic register
   // ****************************************************************
   reg [DATA_W-1:0] diag_q;

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         diag_q <= `PES_DIAG_RESET;
      end else if (i_ce) begin
         diag_q <= `PES_DIAG_RESET;
         diag_q[`PES_DIAG_RX_DETECT_BIT] <= sync_lvl[NUM_EVENTS];
         diag_q[`PES_DIAG_RX_LOCK_BIT] <= sync_lvl[NUM_EVENTS+1];
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   // Read data shows the flags as they stood before the clearing read, so
   // software sees every event that the read is about to discard.
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata <= {DATA_W{1'b0}};
         o_reg_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_reg_rvalid <= i_reg_rd;
         if (rd_event) begin
            o_reg_rdata <= {enable_q, flag_q};
         end else if (rd_diag) begin
            o_reg_rdata <= diag_q;
         end else if (i_reg_rd) begin
            o_reg_rdata <= {DATA_W{1'b0}};
         end
      end
   end
endmodule // pes_event_status

/* File: core/pes_sync3.v */
/*
 * Three-stage synchroniser bank for inputs from outside the clock domain.
 * Assumes i_clk is the system clock; a change is accepted once the second
 * and third stage agree, so a one-stage glitch never reaches o_level.
 */
`timescale 1ns/1ps
module pes_sync3 #(
   parameter WIDTH = 8
) (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_ce,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_level
);
   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   reg [WIDTH-1:0] level_q;
   genvar g;

   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         always @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               level_q[g] <= 1'b0;
            end else if (i_ce) begin
               s1_q[g] <= i_async[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  level_q[g] <= s3_q[g];
               end
            end
         end
      end
   endgenerate

   assign o_level = level_q;
endmodule // pes_sync3

/* File: sim/pes_event_status_sva.sv */
/* Checker for the event status block: register answers and interrupt gating.
   Assumes it is bound to pes_event_status with the clock enable held high. */
`timescale 1ns/1ps
module pes_event_status_sva (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_reg_rd,
   input wire i_reg_wr,
   input wire [4:0] i_reg_addr,
   input wire [15:0] i_reg_wdata,
   input wire [15:0] o_reg_rdata,
   input wire o_reg_rvalid,
   input wire o_mac_raw_interrupt_status
);
   // ****************************************
   // Register port and interrupt relations
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   chk_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read strobe got no answer");
   chk_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
      else $error("answer without a read");
   chk_rdata_hold: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
      else $error("read data moved between reads");
   chk_unmapped_zero: assert property (o_reg_rvalid && $past(i_reg_addr) != 5'h11
      && $past(i_reg_addr) != 5'h12 |-> o_reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_diag_reserved: assert property (o_reg_rvalid && $past(i_reg_addr) == 5'h12
      |-> (o_reg_rdata & 16'hE7FF) == 16'h0000) else $error("diagnostic spare bits set");
   chk_enable_store: assert property ((i_reg_wr && i_reg_addr == 5'h11) ##1 !i_reg_wr
      ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == 5'h11)
      |=> o_reg_rdata[15:8] == $past(i_reg_wdata[15:8], 3)) else $error("enable readback wrong");
   chk_mask_all: assert property (i_reg_wr && !i_reg_rd && i_reg_addr == 5'h11
      && i_reg_wdata[15:8] == 8'h00 |=> !o_mac_raw_interrupt_status)
      else $error("interrupt with all enables off");
   chk_read_clear: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 5'h11
      |=> !o_mac_raw_interrupt_status) else $error("interrupt kept after clearing read");
   chk_irq_drop: assert property ($fell(o_mac_raw_interrupt_status)
      |-> $past(i_reg_rd || i_reg_wr)) else $error("interrupt fell without register access");
endmodule // pes_event_status_sva

/* File: sim/pes_event_status_tb.sv */
/* Testbench for pes_event_status: register tasks, event stimulus, checks.
   Assumes the checker and the MAC model are compiled before this file. */
`timescale 1ns/1ps
module pes_event_status_tb;
   reg i_clk = 1'b0;
   reg i_rst_b = 1'b0;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg clr = 1'b0;
   reg [4:0] addr = 5'h00;
   reg [15:0] wdata = 16'h0000;
   reg [9:0] ev = 10'h000;
   reg [15:0] r1;
   reg [15:0] r2;
   reg [7:0] b;
   wire [15:0] rdata;
   wire rvalid;
   wire irq;
   wire raw;
   integer n_mismatch = 0;
   integer checks = 0;
   integer i;
   pes_event_status u_pes_event_status (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
      .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_jabber(ev[7]), .i_rx_error(ev[6]),
      .i_page_received(ev[5]), .i_parallel_fault(ev[4]), .i_partner_ack(ev[3]),
      .i_link_ok(~ev[2]), .i_remote_fault(ev[1]), .i_negotiation_done(ev[0]),
      .i_receive_detect(ev[8]), .i_receive_lock(ev[9]), .o_mac_raw_interrupt_status(irq));
   pes_mac_model u_pes_mac_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_phy_irq(irq),
      .i_clr(clr), .o_raw_status(raw));
   // ****************************************
   // Tasks
   // ****************************************
   task finish_test;
      begin
         if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task cmpw(input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
         end
      end
   endtask
   task cmpb(input e, input g);
      cmpw({15'h0000, e}, {15'h0000, g});
   endtask
   task wrreg(input [4:0] a, input [15:0] d);
      begin
         @(posedge i_clk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge i_clk);
         wr <= 1'b0;
         #1;
      end
   endtask
   task rdreg(input [4:0] a, output [15:0] d);
      begin
         @(posedge i_clk);
         rd <= 1'b1;
         addr <= a;
         @(posedge i_clk);
         rd <= 1'b0;
         #1;
         cmpb(1'b1, rvalid);
         d = rdata;
      end
   endtask
   // ****************************************
   // Clock, watchdog and main sequence
   // ****************************************
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch = n_mismatch + 1;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rdreg(5'h11, r1);
      cmpw(16'h0000, r1);
      rdreg(5'h12, r1);
      cmpw(16'h0000, r1);
      rdreg(5'h05, r1);
      cmpw(16'h0000, r1);
      for (i = 0; i < 8; i = i + 1) begin
         b = 8'h01 << i;
         wrreg(5'h11, {~b, 8'hFF});
         @(posedge i_clk) ev[i] <= 1'b1;
         repeat (8) @(posedge i_clk);
         #1 cmpb(1'b0, irq);
         cmpb(1'b0, raw);
         wrreg(5'h11, {b, 8'h00});
         cmpb(1'b1, irq);
         rdreg(5'h11, r1);
         cmpw({b, b}, r1);
         cmpb(1'b1, raw);
         cmpb(1'b0, irq);
         rdreg(5'h11, r1);
         cmpw({b, 8'h00}, r1);
         @(posedge i_clk) ev[i] <= 1'b0;
         clr <= 1'b1;
         @(posedge i_clk) clr <= 1'b0;
      end
      @(posedge i_clk) ev[8] <= 1'b1;
      repeat (8) @(posedge i_clk);
      rdreg(5'h12, r1);
      cmpw(16'h1000, r1);
      @(posedge i_clk) ev[9] <= 1'b1;
      repeat (8) @(posedge i_clk);
      wrreg(5'h12, 16'hFFFF);
      rdreg(5'h12, r1);
      cmpw(16'h1800, r1);
      wrreg(5'h11, 16'h0000);
      for (i = 0; i < 7; i = i + 1) begin
         @(posedge i_clk) ev[0] <= 1'b1;
         repeat (i) @(posedge i_clk);
         rdreg(5'h11, r1);
         repeat (8) @(posedge i_clk);
         rdreg(5'h11, r2);
         cmpb(1'b1, r1[0] | r2[0]);
         @(posedge i_clk) ev[0] <= 1'b0;
         repeat (8) @(posedge i_clk);
      end
      finish_test;
   end
endmodule // pes_event_status_tb
bind pes_event_status pes_event_status_sva u_pes_event_status_sva (.i_clk, .i_rst_b,
   .i_reg_rd, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
   .o_mac_raw_interrupt_status);

/* File: sim/pes_mac_model.sv */
/* MAC side model: a sticky raw interrupt status bit fed by the block.
   Assumes the same clock and reset as the block. */
`timescale 1ns/1ps
module pes_mac_model (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_phy_irq,
   input wire i_clr,
   output reg o_raw_status
);
   // ****************************************
   // Raw status latch
   // ****************************************
   // Sticky, so a short interrupt is still seen by slow software.
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) o_raw_status <= 1'b0;
      else o_raw_status <= (o_raw_status & ~i_clr) | i_phy_irq;
   end
endmodule // pes_mac_model
